/* File: hdl/ctm_map.svh */
// register addresses, field positions, reset values and codes of the cycle timer
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH

`define CTM_ADDR_AUTOCLR 32'h3002_6040
`define CTM_ADDR_TASK_CFG 32'h3002_A000
`define CTM_ADDR_PC_S1 32'h3002_A020
`define CTM_ADDR_PC_S4 32'h3002_A02C
`define CTM_ADDR_TRIG_1 32'h3002_A040
`define CTM_ADDR_TRIG_2 32'h3002_A044
`define CTM_ADDR_TASK_STAT 32'h3002_A048
`define CTM_ADDR_GLOBAL 32'h3002_E000
`define CTM_ADDR_COMPEN 32'h3002_E008
`define CTM_ADDR_CNT_LO 32'h3002_E010
`define CTM_ADDR_CNT_HI 32'h3002_E014
`define CTM_ADDR_CAP_CFG 32'h3002_E018
`define CTM_ADDR_LATCH_CAPTURE_6 32'h3002_E050
`define CTM_ADDR_CMP_CFG 32'h3002_E070
`define CTM_ADDR_CMP_STAT 32'h3002_E074
`define CTM_ADDR_PERIOD_COMPARE 32'h3002_E078
`define CTM_ADDR_SYNC_START_COMPARE 32'h3002_E080
`define CTM_ADDR_SYNC_CTRL 32'h3002_E180
`define CTM_ADDR_SYNC_PW 32'h3002_E190
`define CTM_ADDR_PAD_SEL 32'h3002_F000
`define CTM_ADDR_ROUTE 32'h3002_F004

`define CTM_GCFG_EN_BIT 0
`define CTM_GCFG_DINC_LSB 4
`define CTM_GCFG_CINC_LSB 8
`define CTM_GCFG_RESET 32'h0000_0040
`define CTM_COMPEN_W 24
`define CTM_CMPCFG_WRAP_BIT 0
`define CTM_CMPCFG_PERIOD_COMPARE_BIT 1
`define CTM_CMPCFG_SYNC_START_COMPARE_BIT 2
`define CTM_SYNC_GEN_BIT 0
`define CTM_SYNC_PULSE_0_ENABLE_BIT 1
`define CTM_SYNC_PULSE_0_REP_BIT 3
`define CTM_PW_W 16
`define CTM_LATCH_CAPTURE_6_BIT 6
`define CTM_AUTOCLR_BIT 0
`define CTM_TASK_MODE_LSB 0
`define CTM_TASK_MODE_GP 2'h2
`define CTM_TASK_EN_S1_BIT 16
`define CTM_TASK_EN_S4_BIT 19
`define CTM_TRIG_PERIOD_COMPARE 8'h10
`define CTM_TRIG_SYNC_START_COMPARE 8'h11
`define CTM_TRIG_LATCH_CAPTURE_6 8'h16
`define CTM_TRIG_HOST 8'h88
`define CTM_PAD_SYNC 4'h2
`define CTM_ROUTE_LATCH 8'h04

`endif

/* File: hdl/ctm_pkg.sv */
// types shared by the cycle timer
package ctm_pkg;
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
	} ctm_launch_t;

	typedef struct packed {
		logic [31:0] pc;
		logic [7:0] flags;
	} ctm_core_state_t;

	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic [7:0] flags;
	} ctm_resume_t;

	typedef enum logic {
		CTM_TASK_IDLE = 1'b0,
		CTM_TASK_RUN = 1'b1
	} ctm_task_st_t;

	typedef enum logic {
		CTM_SYNC_LOW = 1'b0,
		CTM_SYNC_HIGH = 1'b1
	} ctm_sync_st_t;
endpackage

/* File: hdl/ctm_cycle_timer.sv */
// cycle timer with sync pulse, latch capture and subtask launcher
//
// Overview of operation
// - counter readable as low and high words
// - compare event 0 on counter reaching compare
// - wrap to zero at compare 0 when enabled
// - compare 0 of period minus increment sets period
// - compare 1 places sync pulse start
// - counter advances by default increment each tick while compensation count is zero
// - sync high for width field plus one
// - enables with repeat clear give single shot
// - autoclear bit clears compare flags in hardware
// - mode 2 is general purpose; per-subtask enables
// - trigger launches core at subtask program address
// - select 16 makes compare 0 trigger subtask 1
// - select 136 makes host event trigger subtask 4
// - receive buffer full raises host event
// - capture bit 6 latches counter on latch event
// - pad select 2 routes sync out and latch in
// - route select 4 feeds latch pin to latch 0
// - compensation increment used for compensation count ticks
// - preemption saves pc and flags; end restores them
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ctm_map.svh"

module ctm_cycle_timer
	import ctm_pkg::*;
#(
	parameter int CNT_W = 64
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic latch_in_pin_signal,
	output logic sync_out_pin_signal,
	output logic sync_out_pin_oe,
	input wire logic rx_buffer_full,
	input wire ctm_core_state_t core_state,
	input wire logic task_end,
	output ctm_launch_t task_launch,
	output ctm_resume_t task_resume,
	output logic [1:0] cmp_flags
);

	logic [1:0] rst_q;
	logic rst_n;

	logic [31:0] gcfg_q, cmp_cfg_q, period_compare_q, sync_start_compare_q, sync_ctrl_q, cap_cfg_q;
	logic [31:0] pc_s1_q, pc_s4_q, trig1_q, trig2_q, task_cfg_q, latch_capture_6_q;
	logic [`CTM_PW_W-1:0] pw_q;
	logic [`CTM_COMPEN_W-1:0] compen_q;
	logic [3:0] pad_sel_q;
	logic [7:0] route_q;
	logic autoclr_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0] flag_q, flag_d;
	logic period_compare_hit, sync_start_compare_hit, wrap;
	logic [3:0] inc;
	logic latch_prev_q, latch_in, latch_rise, latch_capture_6_ev;
	logic rx_prev_q, host_ev;
	logic sync_on, sync_on_prev_q, armed_q;
	ctm_sync_st_t sync_st_q;
	logic [`CTM_PW_W-1:0] pw_cnt_q;
	ctm_task_st_t task_st_q;
	ctm_core_state_t saved_q;
	logic [1:0] sub_fire;

	function automatic logic wr_hit(input logic [31:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	function automatic logic trig_pick(input logic [7:0] sel, input logic c0, input logic c1,
		input logic cap, input logic host);
		unique case (sel)
			`CTM_TRIG_PERIOD_COMPARE: trig_pick = c0;
			`CTM_TRIG_SYNC_START_COMPARE: trig_pick = c1;
			`CTM_TRIG_LATCH_CAPTURE_6: trig_pick = cap;
			`CTM_TRIG_HOST: trig_pick = host;
			default: trig_pick = 1'b0;
		endcase
	endfunction

	// reset release through two stages
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// plain configuration registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gcfg_q <= `CTM_GCFG_RESET;
			cmp_cfg_q <= 32'h0000_0000;
			period_compare_q <= 32'h0000_0000;
			sync_start_compare_q <= 32'h0000_0000;
			sync_ctrl_q <= 32'h0000_0000;
			pw_q <= 16'h0000;
			cap_cfg_q <= 32'h0000_0000;
			autoclr_q <= 1'b0;
			task_cfg_q <= 32'h0000_0000;
			pc_s1_q <= 32'h0000_0000;
			pc_s4_q <= 32'h0000_0000;
			trig1_q <= 32'h0000_0000;
			trig2_q <= 32'h0000_0000;
			pad_sel_q <= 4'h0;
			route_q <= 8'h00;
		end else begin
			if (wr_hit(`CTM_ADDR_GLOBAL)) gcfg_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_CMP_CFG)) cmp_cfg_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_PERIOD_COMPARE)) period_compare_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_SYNC_START_COMPARE)) sync_start_compare_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_SYNC_CTRL)) sync_ctrl_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_SYNC_PW)) pw_q <= reg_wdata[`CTM_PW_W-1:0];
			if (wr_hit(`CTM_ADDR_CAP_CFG)) cap_cfg_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_AUTOCLR)) autoclr_q <= reg_wdata[`CTM_AUTOCLR_BIT];
			if (wr_hit(`CTM_ADDR_TASK_CFG)) task_cfg_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_PC_S1)) pc_s1_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_PC_S4)) pc_s4_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_TRIG_1)) trig1_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_TRIG_2)) trig2_q <= reg_wdata;
			if (wr_hit(`CTM_ADDR_PAD_SEL)) pad_sel_q <= reg_wdata[3:0];
			if (wr_hit(`CTM_ADDR_ROUTE)) route_q <= reg_wdata[7:0];
		end
	end

	// counter compare and step
	assign period_compare_hit = cmp_cfg_q[`CTM_CMPCFG_PERIOD_COMPARE_BIT] && (cnt_q[31:0] == period_compare_q);
	assign sync_start_compare_hit = cmp_cfg_q[`CTM_CMPCFG_SYNC_START_COMPARE_BIT] && (cnt_q[31:0] == sync_start_compare_q);
	assign wrap = period_compare_hit && cmp_cfg_q[`CTM_CMPCFG_WRAP_BIT];
	assign inc = (compen_q != '0) ? gcfg_q[`CTM_GCFG_CINC_LSB +: 4]
		: gcfg_q[`CTM_GCFG_DINC_LSB +: 4];

	always_comb begin
		cnt_d = cnt_q;
		if (gcfg_q[`CTM_GCFG_EN_BIT]) begin
			cnt_d = wrap ? '0 : cnt_q + CNT_W'(inc);
		end
	end

	// software write to either word wins over the step
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (wr_hit(`CTM_ADDR_CNT_LO)) begin
			cnt_q <= {cnt_q[CNT_W-1:32], reg_wdata};
		end else if (wr_hit(`CTM_ADDR_CNT_HI)) begin
			cnt_q <= {reg_wdata[CNT_W-33:0], cnt_q[31:0]};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// compensation count runs down one per tick at the alternate increment
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			compen_q <= '0;
		end else if (wr_hit(`CTM_ADDR_COMPEN)) begin
			compen_q <= reg_wdata[`CTM_COMPEN_W-1:0];
		end else if (gcfg_q[`CTM_GCFG_EN_BIT] && compen_q != '0) begin
			compen_q <= compen_q - 1'b1;
		end
	end

	// compare flags: hardware set beats any clear in the same cycle
	always_comb begin
		flag_d = flag_q;
		if (autoclr_q) begin
			flag_d = 2'b00;
		end else if (wr_hit(`CTM_ADDR_CMP_STAT)) begin
			flag_d = flag_q & ~reg_wdata[1:0];
		end
		flag_d = flag_d | {sync_start_compare_hit, period_compare_hit};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 2'b00;
			cmp_flags <= 2'b00;
		end else begin
			flag_q <= flag_d;
			cmp_flags <= flag_d;
		end
	end

	// latch path: pad function, then router, then rising edge
	assign latch_in = latch_in_pin_signal && (pad_sel_q == `CTM_PAD_SYNC)
		&& (route_q == `CTM_ROUTE_LATCH);
	assign latch_rise = latch_in && !latch_prev_q;
	assign latch_capture_6_ev = latch_rise && cap_cfg_q[`CTM_LATCH_CAPTURE_6_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_prev_q <= 1'b0;
			latch_capture_6_q <= 32'h0000_0000;
		end else begin
			latch_prev_q <= latch_in;
			if (latch_capture_6_ev) latch_capture_6_q <= cnt_q[31:0];
		end
	end

	// receive buffer filling up is the host event
	assign host_ev = rx_buffer_full && !rx_prev_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_q <= 1'b0;
		end else begin
			rx_prev_q <= rx_buffer_full;
		end
	end

	// sync pulse: re-armed only by an off-to-on edge of the enables
	assign sync_on = sync_ctrl_q[`CTM_SYNC_GEN_BIT] && sync_ctrl_q[`CTM_SYNC_PULSE_0_ENABLE_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_on_prev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			sync_on_prev_q <= sync_on;
			if (!sync_on) begin
				armed_q <= 1'b0;
			end else if (!sync_on_prev_q) begin
				armed_q <= 1'b1;
			end else if (sync_start_compare_hit && !sync_ctrl_q[`CTM_SYNC_PULSE_0_REP_BIT]) begin
				armed_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_st_q <= CTM_SYNC_LOW;
			pw_cnt_q <= '0;
			sync_out_pin_signal <= 1'b0;
			sync_out_pin_oe <= 1'b0;
		end else begin
			sync_out_pin_oe <= (pad_sel_q == `CTM_PAD_SYNC);
			unique case (sync_st_q)
				CTM_SYNC_LOW: begin
					if (sync_on && armed_q && sync_start_compare_hit) begin
						sync_st_q <= CTM_SYNC_HIGH;
						pw_cnt_q <= pw_q;
						sync_out_pin_signal <= (pad_sel_q == `CTM_PAD_SYNC);
					end
				end
				CTM_SYNC_HIGH: begin
					if (!sync_on || pw_cnt_q == '0) begin
						sync_st_q <= CTM_SYNC_LOW;
						sync_out_pin_signal <= 1'b0;
					end else begin
						pw_cnt_q <= pw_cnt_q - 1'b1;
					end
				end
			endcase
		end
	end

	// subtask triggers, subtask 1 has priority
	assign sub_fire[0] = task_cfg_q[`CTM_TASK_EN_S1_BIT]
		&& trig_pick(trig1_q[7:0], flag_d[0] && period_compare_hit, sync_start_compare_hit, latch_capture_6_ev, host_ev);
	assign sub_fire[1] = task_cfg_q[`CTM_TASK_EN_S4_BIT]
		&& trig_pick(trig2_q[7:0], flag_d[0] && period_compare_hit, sync_start_compare_hit, latch_capture_6_ev, host_ev);

	// one level of preemption; triggers while a subtask runs are dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			task_st_q <= CTM_TASK_IDLE;
			saved_q <= '0;
			task_launch <= '0;
			task_resume <= '0;
		end else begin
			task_launch.valid <= 1'b0;
			task_resume.valid <= 1'b0;
			unique case (task_st_q)
				CTM_TASK_IDLE: begin
					if (task_cfg_q[`CTM_TASK_MODE_LSB +: 2] == `CTM_TASK_MODE_GP
						&& sub_fire != 2'b00) begin
						task_st_q <= CTM_TASK_RUN;
						saved_q <= core_state;
						task_launch.valid <= 1'b1;
						task_launch.pc <= sub_fire[0] ? pc_s1_q : pc_s4_q;
					end
				end
				CTM_TASK_RUN: begin
					if (task_end) begin
						task_st_q <= CTM_TASK_IDLE;
						task_resume.valid <= 1'b1;
						task_resume.pc <= saved_q.pc;
						task_resume.flags <= saved_q.flags;
					end
				end
			endcase
		end
	end

	// register read, data in the following cycle, unmapped reads zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CTM_ADDR_GLOBAL: reg_rdata <= gcfg_q;
				`CTM_ADDR_COMPEN: reg_rdata <= 32'(compen_q);
				`CTM_ADDR_CNT_LO: reg_rdata <= cnt_q[31:0];
				`CTM_ADDR_CNT_HI: reg_rdata <= cnt_q[63:32];
				`CTM_ADDR_CAP_CFG: reg_rdata <= cap_cfg_q;
				`CTM_ADDR_LATCH_CAPTURE_6: reg_rdata <= latch_capture_6_q;
				`CTM_ADDR_CMP_CFG: reg_rdata <= cmp_cfg_q;
				`CTM_ADDR_CMP_STAT: reg_rdata <= {30'h0, flag_q};
				`CTM_ADDR_PERIOD_COMPARE: reg_rdata <= period_compare_q;
				`CTM_ADDR_SYNC_START_COMPARE: reg_rdata <= sync_start_compare_q;
				`CTM_ADDR_SYNC_CTRL: reg_rdata <= sync_ctrl_q;
				`CTM_ADDR_SYNC_PW: reg_rdata <= 32'(pw_q);
				`CTM_ADDR_AUTOCLR: reg_rdata <= {31'h0, autoclr_q};
				`CTM_ADDR_TASK_CFG: reg_rdata <= task_cfg_q;
				`CTM_ADDR_PC_S1: reg_rdata <= pc_s1_q;
				`CTM_ADDR_PC_S4: reg_rdata <= pc_s4_q;
				`CTM_ADDR_TRIG_1: reg_rdata <= trig1_q;
				`CTM_ADDR_TRIG_2: reg_rdata <= trig2_q;
				`CTM_ADDR_TASK_STAT: reg_rdata <= {31'h0, task_st_q == CTM_TASK_RUN};
				`CTM_ADDR_PAD_SEL: reg_rdata <= {28'h0, pad_sel_q};
				`CTM_ADDR_ROUTE: reg_rdata <= {24'h0, route_q};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [`CTM_PW_W:0] chk_hi_cnt_q;
	logic [31:0] chk_pc_prev_q, chk_pc_q;
	// helpers kept apart from the design path so the checks do not mirror it
	always_ff @(posedge core_clk) chk_hi_cnt_q <= sync_out_pin_signal ? chk_hi_cnt_q + 1'b1 : '0;
	always_ff @(posedge core_clk) chk_pc_prev_q <= core_state.pc;
	always_ff @(posedge core_clk) if (task_launch.valid) chk_pc_q <= chk_pc_prev_q;

	chk_wrap_to_zero: assert property (
		wrap && !reg_wr |=> cnt_q == '0)
		else $error("counter did not wrap at period compare");
	chk_step_default: assert property (
		gcfg_q[0] && !period_compare_hit && compen_q == '0 && !reg_wr
		|=> cnt_q == $past(cnt_q) + CNT_W'($past(gcfg_q[7:4])))
		else $error("counter step differs from default increment");
	chk_step_compen: assert property (
		gcfg_q[0] && !period_compare_hit && compen_q != '0 && !reg_wr
		|=> cnt_q == $past(cnt_q) + CNT_W'($past(gcfg_q[11:8])))
		else $error("counter step differs from compensation increment");
	chk_flag_visible: assert property (
		period_compare_hit |-> flag_d[0] ##1 cmp_flags[0])
		else $error("compare flag not raised on match");
	chk_autoclear_flag: assert property (
		autoclr_q && !period_compare_hit && !sync_start_compare_hit |=> flag_q == 2'b00)
		else $error("compare flags not cleared by hardware");
	chk_sync_start: assert property (
		sync_st_q == CTM_SYNC_LOW && sync_on && armed_q && sync_start_compare_hit && pad_sel_q == 4'h2
		|=> sync_out_pin_signal)
		else $error("sync pulse did not start at compare 1");
	chk_sync_width: assert property (
		$fell(sync_out_pin_signal) && sync_on && $stable(pw_q) |-> chk_hi_cnt_q == {1'b0, pw_q} + 1'b1)
		else $error("sync pulse width is not width plus one");
	chk_single_shot: assert property (
		sync_st_q == CTM_SYNC_HIGH && !sync_ctrl_q[3] && $stable(sync_on) |-> !armed_q)
		else $error("single shot sync stayed armed");
	chk_capture_value: assert property (
		latch_capture_6_ev |=> latch_capture_6_q == $past(cnt_q[31:0]))
		else $error("capture 6 missed the counter value");
	chk_launch_pc: assert property (
		task_st_q == CTM_TASK_IDLE && task_cfg_q[1:0] == 2'h2 && sub_fire[0]
		|=> task_launch.valid && task_launch.pc == $past(pc_s1_q))
		else $error("subtask 1 launched at wrong address");
	chk_resume_state: assert property (
		task_st_q == CTM_TASK_RUN && task_end |=> task_resume.valid && task_resume.pc == chk_pc_q)
		else $error("resume did not restore saved program counter");
	chk_read_low: assert property (
		reg_rd && reg_addr == `CTM_ADDR_CNT_LO |=> reg_rdata == $past(cnt_q[31:0]))
		else $error("low counter word read wrong");

	cov_wrap: cover property (wrap);
	cov_sync_pulse: cover property ($fell(sync_out_pin_signal));
	cov_capture: cover property (latch_capture_6_ev);
	cov_launch_resume: cover property (task_launch.valid ##[1:50] task_resume.valid);
endmodule

/* File: tb/ctm_peer.sv */
// far-side model: sync source of the other chip and the firmware core
`timescale 1ns/1ps

module ctm_peer
	import ctm_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic latch_fire,
	input wire ctm_launch_t task_launch,
	output logic latch_in_pin_signal,
	output logic task_end,
	output ctm_core_state_t core_state
);
	logic [3:0] pulse_q;
	logic [3:0] run_q;
	logic running_q;

	// other chip's sync pulse: ten cycles high, driven low between pulses
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pulse_q <= 4'h0;
		end else if (latch_fire) begin
			pulse_q <= 4'hA;
		end else if (pulse_q != 4'h0) begin
			pulse_q <= pulse_q - 4'h1;
		end
	end

	assign latch_in_pin_signal = (pulse_q != 4'h0);

	// subtask runs long enough that the bench can finish its re-arm writes first
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			running_q <= 1'b0;
			run_q <= 4'h0;
			task_end <= 1'b0;
		end else begin
			task_end <= 1'b0;
			if (task_launch.valid) begin
				running_q <= 1'b1;
				run_q <= 4'h0;
			end else if (running_q) begin
				run_q <= run_q + 4'h1;
				if (run_q == 4'hC) begin
					task_end <= 1'b1;
					running_q <= 1'b0;
				end
			end
		end
	end

	// preempted code parks at a fixed spot; a subtask walks from its entry
	always_comb begin
		core_state.pc = running_q ? task_launch.pc + {28'h0, run_q} : 32'h0000_0400;
		core_state.flags = running_q ? 8'h00 : 8'h5A;
	end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the cycle timer
`timescale 1ns/1ps
`include "ctm_map.svh"

module tb
	import ctm_pkg::*;
;
	logic core_clk, resetn, reg_wr, reg_rd, latch_fire, rx_buffer_full, task_end;
	logic sync_out_pin_signal, sync_out_pin_oe, latch_in_pin_signal;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, v0, v1;
	logic [1:0] cmp_flags;
	ctm_core_state_t core_state;
	ctm_launch_t task_launch;
	ctm_resume_t task_resume;
	int fails, checked, cyc, t0, t1, rises, launches;

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) cyc <= cyc + 1;
	always @(posedge sync_out_pin_signal) rises++;
	always @(posedge core_clk) if (task_launch.valid === 1'b1) launches++;

	ctm_cycle_timer i_ctm_cycle_timer (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .latch_in_pin_signal(latch_in_pin_signal),
		.sync_out_pin_signal(sync_out_pin_signal), .sync_out_pin_oe(sync_out_pin_oe),
		.rx_buffer_full(rx_buffer_full), .core_state(core_state), .task_end(task_end),
		.task_launch(task_launch), .task_resume(task_resume), .cmp_flags(cmp_flags));

	ctm_peer i_ctm_peer (.core_clk(core_clk), .resetn(resetn), .latch_fire(latch_fire),
		.task_launch(task_launch), .latch_in_pin_signal(latch_in_pin_signal),
		.task_end(task_end), .core_state(core_state));

	task automatic summarize();
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(nm, exp, d);
	endtask

	// two reads two ticks apart: the gap shows the step size in use
	task automatic rate(input string nm, input logic [31:0] exp);
		rd(`CTM_ADDR_CNT_LO, v0);
		rd(`CTM_ADDR_CNT_LO, v1);
		chk(nm, exp, v1 - v0);
	endtask

	task automatic fire();
		@(posedge core_clk);
		latch_fire <= 1'b1;
		@(posedge core_clk);
		latch_fire <= 1'b0;
		repeat (15) @(posedge core_clk);
	endtask

	task automatic wait_for(input int sel, input int lim);
		logic hit;
		for (int i = 0; i < lim; i++) begin
			@(posedge core_clk);
			#1;
			case (sel)
				0: hit = (cmp_flags[0] === 1'b1);
				1: hit = (sync_out_pin_signal === 1'b1);
				2: hit = (sync_out_pin_signal === 1'b0);
				3: hit = (task_launch.valid === 1'b1);
				default: hit = (task_resume.valid === 1'b1);
			endcase
			if (hit) return;
		end
		chk("wait", 32'h0000_0001, 32'h0000_0000);
		summarize();
	endtask

	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		latch_fire = 1'b0;
		rx_buffer_full = 1'b0;
		{fails, checked, cyc, rises, launches} = '0;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("oe idle", 32'h0, {31'h0, sync_out_pin_oe});
		rchk("global cfg", `CTM_ADDR_GLOBAL, `CTM_GCFG_RESET);
		rchk("unmapped", 32'h3002_EFF0, 32'h0);
		wr(`CTM_ADDR_PAD_SEL, 32'h0000_0002);
		wr(`CTM_ADDR_ROUTE, 32'h0000_0004);
		wr(`CTM_ADDR_CAP_CFG, 32'h0000_0040);
		wr(`CTM_ADDR_CNT_LO, 32'h0000_1234);
		chk("oe", 32'h1, {31'h0, sync_out_pin_oe});
		fire();
		rchk("capture", `CTM_ADDR_LATCH_CAPTURE_6, 32'h0000_1234);
		wr(`CTM_ADDR_ROUTE, 32'h0000_0000);
		wr(`CTM_ADDR_CNT_LO, 32'h0000_5678);
		fire();
		rchk("capture unrouted", `CTM_ADDR_LATCH_CAPTURE_6, 32'h0000_1234);
		wr(`CTM_ADDR_CNT_HI, 32'h0000_0001);
		rchk("count high", `CTM_ADDR_CNT_HI, 32'h0000_0001);
		rchk("count low", `CTM_ADDR_CNT_LO, 32'h0000_5678);
		wr(`CTM_ADDR_CNT_HI, 32'h0000_0000);
		wr(`CTM_ADDR_GLOBAL, 32'h0000_0041);
		rate("default step", 32'h0000_0008);
		wr(`CTM_ADDR_COMPEN, 32'h0000_0064);
		wr(`CTM_ADDR_GLOBAL, 32'h0000_0341);
		rate("slow step", 32'h0000_0006);
		wr(`CTM_ADDR_COMPEN, 32'h0000_0064);
		wr(`CTM_ADDR_GLOBAL, 32'h0000_0541);
		rate("fast step", 32'h0000_000A);
		wr(`CTM_ADDR_COMPEN, 32'h0000_0000);
		wr(`CTM_ADDR_GLOBAL, 32'h0000_0041);
		wr(`CTM_ADDR_PC_S1, 32'h0000_0100);
		wr(`CTM_ADDR_PC_S4, 32'h0000_0200);
		wr(`CTM_ADDR_TRIG_1, 32'h0000_0010);
		wr(`CTM_ADDR_TRIG_2, 32'h0000_0088);
		wr(`CTM_ADDR_TASK_CFG, 32'h0009_0002);
		wr(`CTM_ADDR_PERIOD_COMPARE, 32'h0000_F420);
		wr(`CTM_ADDR_SYNC_START_COMPARE, 32'h0000_03E4);
		wr(`CTM_ADDR_SYNC_PW, 32'h0000_0009);
		wr(`CTM_ADDR_AUTOCLR, 32'h0000_0001);
		wr(`CTM_ADDR_CNT_LO, 32'h0000_0000);
		wr(`CTM_ADDR_CMP_CFG, 32'h0000_0007);
		wait_for(0, 16000);
		t0 = cyc;
		chk("launch valid", 32'h1, {31'h0, task_launch.valid});
		chk("launch s1", 32'h0000_0100, task_launch.pc);
		@(posedge core_clk);
		#1;
		chk("flag autoclear", 32'h0, {30'h0, cmp_flags});
		wr(`CTM_ADDR_SYNC_CTRL, 32'h0000_0000);
		wr(`CTM_ADDR_SYNC_CTRL, 32'h0000_0003);
		wait_for(4, 20);
		chk("resume pc", 32'h0000_0400, task_resume.pc);
		chk("resume flags", 32'h0000_005A, {24'h0, task_resume.flags});
		wait_for(1, 300);
		chk("sync start", 32'h0000_00FA, cyc - t0);
		t1 = cyc;
		wait_for(2, 20);
		chk("sync width", 32'h0000_000A, cyc - t1);
		rises = 0;
		wait_for(0, 16000);
		chk("period", 32'h0000_3D09, cyc - t0);
		repeat (300) @(posedge core_clk);
		chk("single shot", 32'h0, rises);
		rx_buffer_full <= 1'b1;
		wait_for(3, 10);
		chk("launch s4", 32'h0000_0200, task_launch.pc);
		wait_for(4, 30);
		rx_buffer_full <= 1'b0;
		wr(`CTM_ADDR_TASK_CFG, 32'h0001_0002);
		launches = 0;
		rx_buffer_full <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk("s4 disabled", 32'h0, launches);
		wr(`CTM_ADDR_PERIOD_COMPARE, 32'h0000_07FC);
		wr(`CTM_ADDR_CNT_LO, 32'h0000_0000);
		wr(`CTM_ADDR_SYNC_CTRL, 32'h0000_0000);
		wr(`CTM_ADDR_SYNC_CTRL, 32'h0000_000B);
		wait_for(0, 600);
		rises = 0;
		wait_for(0, 600);
		wait_for(0, 600);
		chk("repeat sync", 32'h0000_0002, rises);
		wr(`CTM_ADDR_TRIG_1, 32'h0000_0016);
		wr(`CTM_ADDR_ROUTE, 32'h0000_0004);
		repeat (20) @(posedge core_clk);
		launches = 0;
		fire();
		chk("capture launch", 32'h0000_0001, launches);
		summarize();
	end
endmodule
